// ### sim/pin_partner.sv
// Board-side model of the eight port pins and the sources behind them.
// Assumes the bench chooses which pins an outside source drives.
`timescale 1ns/1ps

module pin_partner (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // ==========================================================
  // Wire resolution
  // ==========================================================
  // A pin the port drives shows its value, else the outside source.
  // With neither, the pull-up wins, so a released pin never reads stale.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule

// ### sim/serial_shared_gpio_port_tb_top.sv
// Self-checking bench for the shared serial port.
// Assumes the AXI4-Lite slave answers every request; the watchdog bounds
// any wait for an answer.
`timescale 1ns/1ps

module serial_shared_gpio_port_tb_top;
  import gpio_port_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] pin_in, pin_out, pin_oe, ext_en, ext_val;
  serial_to_port_s from_serial;
  port_to_serial_s to_serial;
  int failures, check_count;

  serial_shared_gpio_port i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .from_serial(from_serial), .to_serial(to_serial));

  pin_partner i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // The clock runs at 25 MHz.
  always #20 aclk = ~aclk;

  // ==========================================================
  // Shared tasks
  // ==========================================================
  // Counts a comparison and reports a mismatch at once.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One write; address and data offered together, each released when taken.
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
      end
      if (wready) begin
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp({31'h0, bvalid}, 32'h1);
    cmp({30'h0, bresp}, {30'h0, er});
  endtask

  // One read; the answer is taken at the edge where rvalid is seen.
  task automatic rd(input logic [31:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp({31'h0, rvalid}, 32'h1);
    cmp(rdata, {24'h0, ed});
    cmp({30'h0, rresp}, {30'h0, er});
  endtask

  // Reset is held low for five cycles.
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic end_of_test();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  // Values after reset; the latch shows once the pins turn outputs.
  task automatic t_reset();
    @(negedge aclk);
    cmp(pin_oe, 8'h00);
    cmp(to_serial, 7'h7f);
    // Write address, write data and read address channels stand ready once reset is gone.
    cmp({29'h0, awready, wready, arready}, 32'h7);
    rd(ADDR_PIN_DIRECTION, 8'h00, RESP_OKAY);
    rd(ADDR_ALT_FUNCTION, 8'h00, RESP_OKAY);
    rd(ADDR_DRIVE_MODE, 8'h00, RESP_OKAY);
    rd(ADDR_PORT_DATA, ext_val, RESP_OKAY);
    wr(ADDR_PIN_DIRECTION, 8'hff, 4'h1, RESP_OKAY);
    rd(ADDR_PORT_DATA, 8'hff, RESP_OKAY);
  endtask

  // Mixed directions, and a latch write while every pin is an input.
  task automatic t_dir();
    wr(ADDR_PORT_DATA, 8'h3c, 4'h1, RESP_OKAY);
    @(negedge aclk);
    cmp(pin_out, 8'h3c);
    wr(ADDR_PIN_DIRECTION, 8'ha5, 4'h1, RESP_OKAY);
    @(negedge aclk);
    cmp(pin_oe, 8'ha5);
    rd(ADDR_PORT_DATA, 8'h7e, RESP_OKAY);
    wr(ADDR_PIN_DIRECTION, 8'h00, 4'h1, RESP_OKAY);
    wr(ADDR_PORT_DATA, 8'hc3, 4'h1, RESP_OKAY);
    wr(ADDR_PIN_DIRECTION, 8'hff, 4'h1, RESP_OKAY);
    rd(ADDR_PORT_DATA, 8'hc3, RESP_OKAY);
  endtask

  // Pins lent to the channels in both directions, then handed back.
  task automatic t_func();
    from_serial <= '{transmit: 3'b101, clock_out: 2'b10};
    wr(ADDR_ALT_FUNCTION, 8'hff, 4'h1, RESP_OKAY);
    wr(ADDR_PIN_DIRECTION, 8'h6d, 4'h1, RESP_OKAY);
    @(negedge aclk);
    cmp(pin_out & 8'h6d, 8'h61);
    cmp(pin_oe, 8'h6d);
    cmp(to_serial, 7'h3a);
    wr(ADDR_PIN_DIRECTION, 8'h00, 4'h1, RESP_OKAY);
    @(posedge aclk);
    ext_val <= 8'ha5;
    @(negedge aclk);
    // The channel side chooses between clock and clear-to-send itself.
    cmp(to_serial, 7'h4f);
    wr(ADDR_ALT_FUNCTION, 8'h00, 4'h1, RESP_OKAY);
    wr(ADDR_PIN_DIRECTION, 8'hff, 4'h1, RESP_OKAY);
    @(negedge aclk);
    cmp(to_serial, 7'h7f);
    cmp(pin_out, 8'hc3);
  endtask

  // Open-drain pins only pull low; the rest of the bits stay fixed.
  task automatic t_drive();
    @(posedge aclk);
    ext_en <= 8'h00;
    wr(ADDR_DRIVE_MODE, 8'hff, 4'h1, RESP_OKAY);
    rd(ADDR_DRIVE_MODE, 8'h6d, RESP_OKAY);
    wr(ADDR_PORT_DATA, 8'h00, 4'h1, RESP_OKAY);
    @(negedge aclk);
    cmp(pin_oe, 8'hff);
    cmp(pin_out, 8'h00);
    wr(ADDR_PORT_DATA, 8'hff, 4'h1, RESP_OKAY);
    @(negedge aclk);
    cmp(pin_oe, 8'h92);
    cmp(pin_in, 8'hff);
    wr(ADDR_DRIVE_MODE, 8'h00, 4'h1, RESP_OKAY);
    @(negedge aclk);
    cmp(pin_oe, 8'hff);
  endtask

  // Unmapped place and a write with its byte strobe low.
  task automatic t_bus();
    wr(ADDR_PORT_DATA + 32'h4, 8'h12, 4'h1, RESP_SLVERR);
    rd(ADDR_PORT_DATA + 32'h4, 8'h00, RESP_SLVERR);
    wr(ADDR_PORT_DATA, 8'h55, 4'h0, RESP_OKAY);
    rd(ADDR_PORT_DATA, 8'hff, RESP_OKAY);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 32'h0;
    araddr = 32'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    ext_en = 8'hff;
    ext_val = 8'h5a;
    from_serial = '0;
    failures = 0;
    check_count = 0;
    do_reset();
    t_reset();
    t_dir();
    t_func();
    t_drive();
    t_bus();
    // A second reset in mid-run must clear the registers and set the latch again.
    ext_en <= 8'hff;
    do_reset();
    t_reset();
    end_of_test();
  end

  // The tests need under 200 cycles; this limit is far beyond that.
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule

// ### verilog/gpio_port_pkg.sv
// Constants, register map and carrier types for the shared serial port.
// Assumes a 32-bit AXI4-Lite master and three serial channels nearby.

package gpio_port_pkg;

  // ==========================================================
  // Register indices and byte addresses
  // ==========================================================
  // The printed offsets are not word aligned, so they are indices and the
  // byte address is four times the index, cut to the 32-bit bus.
  localparam logic [31:0] IDX_PORT_DATA = 32'hfffff051;
  localparam logic [31:0] IDX_PIN_DIRECTION = 32'hfffff055;
  localparam logic [31:0] IDX_ALT_FUNCTION = 32'hfffff059;
  localparam logic [31:0] IDX_DRIVE_MODE = 32'hfffff05d;
  localparam logic [31:0] ADDR_PORT_DATA = {IDX_PORT_DATA[29:0], 2'h0};
  localparam logic [31:0] ADDR_PIN_DIRECTION =
    {IDX_PIN_DIRECTION[29:0], 2'h0};
  localparam logic [31:0] ADDR_ALT_FUNCTION = {IDX_ALT_FUNCTION[29:0], 2'h0};
  localparam logic [31:0] ADDR_DRIVE_MODE = {IDX_DRIVE_MODE[29:0], 2'h0};

  // ==========================================================
  // Reset values and field masks
  // ==========================================================
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] FUNCTION_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  // Pins 0, 2, 3, 5 and 6 own a drive-mode bit; the rest read zero.
  localparam logic [7:0] DRIVE_WRITABLE = 8'h6d;
  // Receive-side inputs idle high while their pin is a plain port pin.
  localparam logic INPUT_IDLE = 1'b1;

  // ==========================================================
  // Pin positions of the serial functions
  // ==========================================================
  localparam int PIN_TX0 = 0;
  localparam int PIN_RX0 = 1;
  localparam int PIN_CLK0 = 2;
  localparam int PIN_TX1 = 3;
  localparam int PIN_RX1 = 4;
  localparam int PIN_CLK1 = 5;
  localparam int PIN_TX2 = 6;
  localparam int PIN_RX2 = 7;

  // ==========================================================
  // Bus answers and register selection
  // ==========================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    sel_none = 3'b000,
    sel_data = 3'b001,
    sel_direction = 3'b010,
    sel_function = 3'b011,
    sel_drive = 3'b100
  } reg_sel_e;

  // Signals from the serial channels towards the pins.
  typedef struct packed {
    logic [2:0] transmit;
    logic [1:0] clock_out;
  } serial_to_port_s;

  // Signals from the pins towards the serial channels.
  typedef struct packed {
    logic [2:0] receive;
    logic [1:0] clock_in;
    logic [1:0] clear_to_send;
  } port_to_serial_s;

endpackage

// ### verilog/serial_shared_gpio_port.sv
// Eight-pin general purpose port whose pins can be lent to three serial
// channels, with registers reached over AXI4-Lite.
// Assumes the pad logic resolves pin_out and pin_oe and returns pin_in
// already synchronous to aclk.
//
// Our own choice: the AXI4-Lite slave port.

`timescale 1ns/1ps

module serial_shared_gpio_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire gpio_port_pkg::serial_to_port_s from_serial,
  output gpio_port_pkg::port_to_serial_s to_serial
);
  import gpio_port_pkg::*;

  // ==========================================================
  // Address decoding
  // ==========================================================
  // Used by both the write and the read path.
  function automatic reg_sel_e decode(input logic [31:0] addr);
    if (addr == ADDR_PORT_DATA) begin
      decode = sel_data;
    end else if (addr == ADDR_PIN_DIRECTION) begin
      decode = sel_direction;
    end else if (addr == ADDR_ALT_FUNCTION) begin
      decode = sel_function;
    end else if (addr == ADDR_DRIVE_MODE) begin
      decode = sel_drive;
    end else begin
      decode = sel_none;
    end
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  logic aw_held, next_aw_held; // Write address taken, write pending.
  logic [31:0] aw_addr, next_aw_addr; // Held write address.
  logic w_held, next_w_held; // Write data taken, write pending.
  logic [7:0] w_data, next_w_data; // Held low byte of write data.
  logic w_lane, next_w_lane; // Held strobe of byte lane 0.
  logic bvalid_q, next_bvalid; // Write answer pending.
  logic [1:0] bresp_q, next_bresp; // Write answer code.
  logic rvalid_q, next_rvalid; // Read answer pending.
  logic [31:0] rdata_q, next_rdata; // Read answer data.
  logic [1:0] rresp_q, next_rresp; // Read answer code.
  logic [7:0] pin_direction_reg, next_direction; // 1 makes a pin drive.
  logic [7:0] alt_function_reg, next_function; // 1 lends pin to serial.
  logic [7:0] port_data_latch, next_latch; // Output data latch.
  logic [7:0] drive_mode_reg, next_drive; // 1 makes a pin open-drain.
  logic do_write; // Both halves of a write are in hand.
  reg_sel_e write_sel; // Register hit by the held write address.
  reg_sel_e read_sel; // Register hit by the offered read address.
  logic [7:0] port_read_value; // What a data register read returns.
  logic [7:0] alt_value; // Serial channel output value per pin.
  logic [7:0] alt_drives; // Pin has a serial output function.
  logic [7:0] pin_value; // Value the pin shows when it drives.

  // ==========================================================
  // Bus handshakes
  // ==========================================================
  // Address and data are taken one at a time; a second write waits for
  // the answer to the first, so the master never sees reordering.
  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign write_sel = decode(aw_addr);
  assign read_sel = decode(araddr);
  assign do_write = aw_held && w_held && !bvalid_q;

  assign port_read_value = (pin_direction_reg & port_data_latch) |
                           (~pin_direction_reg & pin_in);

  // Next values of the write channel and the registers.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane = w_lane;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    next_direction = pin_direction_reg;
    next_function = alt_function_reg;
    next_latch = port_data_latch;
    next_drive = drive_mode_reg;
    // Capture whichever half arrives, in either order.
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata[7:0];
      next_w_lane = wstrb[0];
    end
    // Retire the answer once taken.
    if (bvalid_q && bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (write_sel == sel_none) ? RESP_SLVERR : RESP_OKAY;
      // Only lane 0 carries register bits; other lanes are ignored.
      if (w_lane) begin
        case (write_sel)
          sel_data: begin
            next_latch = w_data;
          end
          sel_direction: begin
            next_direction = w_data;
          end
          sel_function: begin
            next_function = w_data;
          end
          sel_drive: begin
            next_drive = w_data & DRIVE_WRITABLE;
          end
          default: begin
            next_drive = drive_mode_reg;
          end
        endcase
      end
    end
  end

  // Next values of the read channel.
  always_comb begin
    next_rvalid = rvalid_q;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    if (rvalid_q && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      // Upper bits always read as zero.
      case (read_sel)
        sel_data: begin
          next_rdata = {24'h000000, port_read_value};
        end
        sel_direction: begin
          next_rdata = {24'h000000, pin_direction_reg};
        end
        sel_function: begin
          next_rdata = {24'h000000, alt_function_reg};
        end
        sel_drive: begin
          next_rdata = {24'h000000, drive_mode_reg};
        end
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // Registering of all state; synchronous active-low reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
      // all pins come up as inputs.
      pin_direction_reg <= DIRECTION_RESET;
      // all pins come up as port pins.
      alt_function_reg <= FUNCTION_RESET;
      port_data_latch <= LATCH_RESET;
      drive_mode_reg <= DRIVE_RESET;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane <= next_w_lane;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
      pin_direction_reg <= next_direction;
      alt_function_reg <= next_function;
      port_data_latch <= next_latch;
      drive_mode_reg <= next_drive;
    end
  end

  // ==========================================================
  // Pin multiplexing
  // ==========================================================
  // Serial outputs per pin; receive-only pins fall back to the latch.
  always_comb begin
    alt_value = port_data_latch;
    alt_drives = 8'h00;
    // transmit data onto pins 0, 3, 6.
    alt_value[PIN_TX0] = from_serial.transmit[0];
    alt_value[PIN_TX1] = from_serial.transmit[1];
    alt_value[PIN_TX2] = from_serial.transmit[2];
    alt_drives[PIN_TX0] = 1'b1;
    alt_drives[PIN_TX1] = 1'b1;
    alt_drives[PIN_TX2] = 1'b1;
    // clock output onto pins 2, 5.
    alt_value[PIN_CLK0] = from_serial.clock_out[0];
    alt_value[PIN_CLK1] = from_serial.clock_out[1];
    alt_drives[PIN_CLK0] = 1'b1;
    alt_drives[PIN_CLK1] = 1'b1;
  end

  // Each pin drives only when its direction bit says output; an
  // open-drain pin drives low and lets the line float for a one.
  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign pin_value[i] = (alt_function_reg[i] && alt_drives[i]) ?
                          alt_value[i] : port_data_latch[i];
    assign pin_out[i] = drive_mode_reg[i] ? 1'b0 : pin_value[i];
    assign pin_oe[i] = pin_direction_reg[i] &&
                       (!drive_mode_reg[i] || !pin_value[i]);
  end

  // Inputs towards the channels idle high unless the pin is lent out.
  // Both clock and clear-to-send see pin 2 or 5; the channel decides
  // which one it listens to, so both are passed on.
  always_comb begin
    // receive data from pins 1, 4, 7.
    to_serial.receive[0] = alt_function_reg[PIN_RX0] ?
                           pin_in[PIN_RX0] : INPUT_IDLE;
    to_serial.receive[1] = alt_function_reg[PIN_RX1] ?
                           pin_in[PIN_RX1] : INPUT_IDLE;
    to_serial.receive[2] = alt_function_reg[PIN_RX2] ?
                           pin_in[PIN_RX2] : INPUT_IDLE;
    to_serial.clock_in[0] = alt_function_reg[PIN_CLK0] ?
                            pin_in[PIN_CLK0] : INPUT_IDLE;
    to_serial.clock_in[1] = alt_function_reg[PIN_CLK1] ?
                            pin_in[PIN_CLK1] : INPUT_IDLE;
    to_serial.clear_to_send[0] = alt_function_reg[PIN_CLK0] ?
                                 pin_in[PIN_CLK0] : INPUT_IDLE;
    to_serial.clear_to_send[1] = alt_function_reg[PIN_CLK1] ?
                                 pin_in[PIN_CLK1] : INPUT_IDLE;
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_data_read;
    arvalid && arready && (read_sel == sel_data);
  endsequence

  sequence s_write_ready;
    aw_held && w_held && !bvalid_q;
  endsequence

  a_dir_reset: assert property (
    $past(!aresetn) |-> (pin_direction_reg == 8'h00))
    else $error("direction not cleared by reset");
  a_func_reset: assert property (
    $past(!aresetn) |-> (alt_function_reg == 8'h00) && (pin_oe == 8'h00))
    else $error("function or enable not cleared by reset");
  a_latch_reset: assert property (
    $past(!aresetn) |-> (port_data_latch == 8'hff))
    else $error("latch not set by reset");
  a_oe_direction: assert property (
    (pin_oe & ~pin_direction_reg) == 8'h00)
    else $error("input pin is driven");
  a_drive_readonly: assert property (
    (drive_mode_reg & 8'h92) == 8'h00)
    else $error("read-only drive bit set");
  a_tx_route: assert property (
    alt_function_reg[3] && pin_direction_reg[3] && !drive_mode_reg[3]
    |-> pin_oe[3] && (pin_out[3] == from_serial.transmit[1]))
    else $error("transmit 1 not on pin 3");
  a_plain_pin: assert property (
    !alt_function_reg[6] && pin_direction_reg[6] && !drive_mode_reg[6]
    |-> pin_out[6] == port_data_latch[6])
    else $error("plain pin does not show latch");
  a_rx_route: assert property (
    alt_function_reg[7] |-> to_serial.receive[2] == pin_in[7])
    else $error("receive 2 not from pin 7");
  a_clock_route: assert property (
    alt_function_reg[5] && pin_direction_reg[5] && !drive_mode_reg[5]
    |-> pin_out[5] == from_serial.clock_out[1])
    else $error("clock 1 not on pin 5");
  a_open_drain: assert property (
    drive_mode_reg[0] && pin_direction_reg[0]
    |-> !pin_out[0] && (pin_oe[0] == !pin_value[0]))
    else $error("open-drain pin drives high");
  a_data_read: assert property (
    s_data_read |=> rvalid && (rdata[7:0] == $past(port_read_value)))
    else $error("data read returns wrong value");
  a_write_answer: assert property (
    s_write_ready |=> bvalid && !aw_held && !w_held)
    else $error("write not answered");

endmodule
